// File: inc/dbc_pkg.sv
// Purpose: constants and command codes of the data-path buffer command decoder
// Assumes: one clock stands in for both processor phases and the memory clock
// Notes: buffer geometry defaults live here; modules take them as parameters
// Behaviour
// - System command and qualifier are sampled together to pick the buffer action.
// - Command 101 qualifier 00 stores pad data into line zero, advancing its counter.
// - Command 101 qualifiers 10 and 11 store pad data into lines two and three.
// - Command 110 qualifier 00 merges pad data with DMA data into line zero.
// - Command 110 qualifiers 01..11 do the same merge into lines one to three.
// - Command 111 qualifier 00 merges read buffer data with DMA data into line zero.
// - Command 111 qualifiers 01..11 do the same merge into lines one to three.
// - Each line has its own slot counter; every load advances it.
// - Memory command is sampled each rising edge to choose the memory bus action.
// - Memory command 000 captures read data next edge and advances read counter.
// - Memory command 001 captures read data one edge later and advances read counter.
// - Memory command 010 does nothing; 011 clears all memory-side counters.
// - Memory commands 100/101 drive write slot next or one later edge, advancing.
// - Memory commands 110/111 drive write data, then zero quadword and advance line.
// - The bridge data link is 32 bits, two-way, driven and sampled on the clock.
// - Active-low reset returns all logic and counters to initial state asynchronously.
package dbc_pkg;
   localparam int DBC_DW = 32;
   localparam int DBC_LINES = 4;
   localparam int DBC_SLOTS = 4;
   localparam logic DBC_OE_ON = 1'b0;
   localparam logic DBC_OE_OFF = 1'b1;
   localparam logic [1:0] DBC_QUAL_HOLD_BIT = 2'h2;

   typedef enum logic [2:0] {
      SYS_RESET_NOP = 3'h0,
      SYS_LOAD_PAD = 3'h1,
      SYS_DMA_READ_SYS = 3'h2,
      SYS_DMA_READ_MEM = 3'h3,
      SYS_MERGE_READ = 3'h4,
      SYS_STORE_LINE = 3'h5,
      SYS_MERGE_SYS_LINE = 3'h6,
      SYS_MERGE_MEM_LINE = 3'h7
   } dbc_sys_cmd_t;

   typedef enum logic [2:0] {
      MC_READ_IMM = 3'h0,
      MC_READ_DLY = 3'h1,
      MC_NOP = 3'h2,
      MC_RESET = 3'h3,
      MC_WRITE_IMM = 3'h4,
      MC_WRITE_DLY = 3'h5,
      MC_WRITE_IMM_LAST = 3'h6,
      MC_WRITE_DLY_LAST = 3'h7
   } dbc_mem_cmd_t;
endpackage : dbc_pkg

// File: inc/dbc_mem_if.sv
// Purpose: memory-side schedule from the command scheduler to the buffer core
// Assumes: all signals are valid for one cycle and used on the next edge
// Notes: the scheduler drives, the core only listens
`timescale 1ns/1ps
interface dbc_mem_if #(parameter int LW = 2, parameter int SW = 2);
   logic rd_we;
   logic [SW-1:0] rd_slot;
   logic wr_drive;
   logic [LW-1:0] wr_line;
   logic [SW-1:0] wr_qw;
   modport sched (output rd_we, rd_slot, wr_drive, wr_line, wr_qw);
   modport core (input rd_we, rd_slot, wr_drive, wr_line, wr_qw);
endinterface : dbc_mem_if

// File: hw/dbc_mem_sched.sv
// Purpose: decode the memory command into timed read captures and write drives
// Assumes: the controller never lets an immediate and a delayed action meet
// Notes: on such a meeting the older delayed action wins
`timescale 1ns/1ps
module dbc_mem_sched
   import dbc_pkg::*;
#(
   parameter int LINES = DBC_LINES,
   parameter int SLOTS = DBC_SLOTS
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // memory command
   input wire logic [2:0] memory_bus_command,
   // schedule to the core
   dbc_mem_if.sched mif
);
   localparam int LW = $clog2(LINES);
   localparam int SW = $clog2(SLOTS);
   localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);

   dbc_mem_cmd_t mc;
   logic [SW-1:0] rd_cnt_q, rd_cnt_d, qw_q, qw_d, a_slot_q, a_slot_d, b_slot_q, b_slot_d;
   logic [LW-1:0] line_q, line_d, a_line_q, a_line_d, b_line_q, b_line_d;
   logic a_rd_q, a_rd_d, a_wr_q, a_wr_d, b_rd_q, b_rd_d, b_wr_q, b_wr_d;

   assign mc = dbc_mem_cmd_t'(memory_bus_command);

   // counters and the two-step action pipe
   always_comb
   begin
      rd_cnt_d = rd_cnt_q;
      qw_d = qw_q;
      line_d = line_q;
      a_rd_d = 1'b0;
      a_wr_d = 1'b0;
      a_slot_d = a_slot_q;
      a_line_d = a_line_q;
      b_rd_d = 1'b0;
      b_wr_d = 1'b0;
      b_slot_d = b_slot_q;
      b_line_d = b_line_q;
      unique case (mc)
         MC_READ_IMM:
         begin
            b_rd_d = 1'b1;
            b_slot_d = rd_cnt_q;
            rd_cnt_d = (rd_cnt_q == LAST_SLOT) ? '0 : rd_cnt_q + 1'b1;
         end
         MC_READ_DLY:
         begin
            a_rd_d = 1'b1;
            a_slot_d = rd_cnt_q;
            rd_cnt_d = (rd_cnt_q == LAST_SLOT) ? '0 : rd_cnt_q + 1'b1;
         end
         MC_NOP: ;
         MC_RESET:
         begin
            rd_cnt_d = '0;
            qw_d = '0;
            line_d = '0;
         end
         MC_WRITE_IMM, MC_WRITE_DLY:
         begin
            a_wr_d = (mc == MC_WRITE_DLY);
            b_wr_d = (mc == MC_WRITE_IMM);
            a_slot_d = qw_q;
            a_line_d = line_q;
            b_slot_d = (mc == MC_WRITE_IMM) ? qw_q : b_slot_q;
            b_line_d = (mc == MC_WRITE_IMM) ? line_q : b_line_q;
            qw_d = (qw_q == LAST_SLOT) ? '0 : qw_q + 1'b1;
         end
         MC_WRITE_IMM_LAST, MC_WRITE_DLY_LAST:
         begin
            a_wr_d = (mc == MC_WRITE_DLY_LAST);
            b_wr_d = (mc == MC_WRITE_IMM_LAST);
            a_slot_d = qw_q;
            a_line_d = line_q;
            b_slot_d = (mc == MC_WRITE_IMM_LAST) ? qw_q : b_slot_q;
            b_line_d = (mc == MC_WRITE_IMM_LAST) ? line_q : b_line_q;
            qw_d = '0;
            line_d = line_q + 1'b1;
         end
      endcase
      // a delayed action is older, so it takes the firing stage
      if (a_rd_q || a_wr_q)
      begin
         b_rd_d = a_rd_q;
         b_wr_d = a_wr_q;
         b_slot_d = a_slot_q;
         b_line_d = a_line_q;
      end
   end

   // async clear of all counters and stages
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_cnt_q <= '0;
         qw_q <= '0;
         line_q <= '0;
         a_rd_q <= 1'b0;
         a_wr_q <= 1'b0;
         a_slot_q <= '0;
         a_line_q <= '0;
         b_rd_q <= 1'b0;
         b_wr_q <= 1'b0;
         b_slot_q <= '0;
         b_line_q <= '0;
      end
      else
      begin
         rd_cnt_q <= rd_cnt_d;
         qw_q <= qw_d;
         line_q <= line_d;
         a_rd_q <= a_rd_d;
         a_wr_q <= a_wr_d;
         a_slot_q <= a_slot_d;
         a_line_q <= a_line_d;
         b_rd_q <= b_rd_d;
         b_wr_q <= b_wr_d;
         b_slot_q <= b_slot_d;
         b_line_q <= b_line_d;
      end
   end

   assign mif.rd_we = b_rd_q;
   assign mif.rd_slot = b_slot_q;
   assign mif.wr_drive = b_wr_q;
   assign mif.wr_line = b_line_q;
   assign mif.wr_qw = b_slot_q;

   property p_read_imm;
      @(posedge clock) disable iff (!reset_n)
      (mc == MC_READ_IMM && !a_rd_q && !a_wr_q) |=> (mif.rd_we && mif.rd_slot == $past(rd_cnt_q));
   endproperty
   a_read_imm: assert property (p_read_imm) else $error("immediate read not captured next edge");

   property p_read_dly;
      @(posedge clock) disable iff (!reset_n)
      (mc == MC_READ_DLY) |=> a_rd_q ##1 (mif.rd_we && mif.rd_slot == $past(rd_cnt_q, 2));
   endproperty
   a_read_dly: assert property (p_read_dly) else $error("delayed read not captured two edges on");

   property p_mem_reset;
      @(posedge clock) disable iff (!reset_n)
      (mc == MC_RESET) |=> (rd_cnt_q == '0 && qw_q == '0 && line_q == '0);
   endproperty
   a_mem_reset: assert property (p_mem_reset) else $error("memory counters not cleared");

   property p_write_last;
      @(posedge clock) disable iff (!reset_n)
      (mc == MC_WRITE_IMM_LAST || mc == MC_WRITE_DLY_LAST) |=> (qw_q == '0 && line_q == $past(line_q) + 1'b1);
   endproperty
   a_write_last: assert property (p_write_last) else $error("last write did not move to next line");

   property p_write_imm;
      @(posedge clock) disable iff (!reset_n)
      (mc == MC_WRITE_IMM && !a_rd_q && !a_wr_q) |=> (mif.wr_drive && mif.wr_qw == $past(qw_q));
   endproperty
   a_write_imm: assert property (p_write_imm) else $error("immediate write not scheduled");
endmodule : dbc_mem_sched

// File: hw/dbc_top.sv
// Purpose: buffer command decoder of one data-path slice
// Assumes: commands and data are synchronous to clock; widths are powers of two
// Notes: buffers reset to zero so no unknown data ever reaches a pin
`timescale 1ns/1ps
module dbc_top
   import dbc_pkg::*;
#(
   parameter int DW = DBC_DW,
   parameter int LINES = DBC_LINES,
   parameter int SLOTS = DBC_SLOTS
)
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // system-side command
   input wire logic [2:0] system_buffer_command,
   input wire logic [1:0] buffer_command_qualifier,
   input wire logic [DW-1:0] system_data_bus,
   // memory-side command and data pins
   input wire logic [2:0] memory_bus_command,
   input wire logic [DW-1:0] memory_data_bus_in,
   output logic [DW-1:0] memory_data_bus_out,
   output logic memory_data_bus_oe_n,
   // bridge data link
   input wire logic [DW-1:0] io_bridge_data_bus_in,
   output logic [DW-1:0] io_bridge_data_bus_out,
   output logic io_bridge_data_bus_oe_n,
   input wire logic io_bridge_load,
   input wire logic io_bridge_drive,
   input wire logic [DW/8-1:0] io_bridge_byte_en,
   input wire logic [$clog2(SLOTS)-1:0] io_bridge_slot
);
   localparam int LW = $clog2(LINES);
   localparam int SW = $clog2(SLOTS);
   localparam int BW = DW / 8;
   localparam int NW = LINES * SLOTS;
   localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);

   // merge: bytes that DMA wrote win over the incoming source
   function automatic logic [DW-1:0] merge_bytes(input logic [DW-1:0] src, input logic [DW-1:0] dma,
                                                 input logic [BW-1:0] be);
      logic [DW-1:0] r;
      r = src;
      for (int b = 0; b < BW; b++)
      begin
         if (be[b])
            r[b*8 +: 8] = dma[b*8 +: 8];
      end
      return r;
   endfunction : merge_bytes

   dbc_mem_if #(.LW(LW), .SW(SW)) mif ();

   dbc_mem_sched #(.LINES(LINES), .SLOTS(SLOTS)) u_sched (
      .clock(clock),
      .reset_n(reset_n),
      .memory_bus_command(memory_bus_command),
      .mif(mif)
   );

   dbc_sys_cmd_t sc;
   logic [LW-1:0] tgt;
   logic [SW-1:0] slot;
   logic [LW+SW-1:0] idx;
   logic [LW+SW-1:0] wr_idx;
   logic [DW-1:0] wbuf_q [NW];
   logic [DW-1:0] wbuf_d [NW];
   logic [DW-1:0] rbuf_q [SLOTS];
   logic [DW-1:0] rbuf_d [SLOTS];
   logic [DW-1:0] dma_q [SLOTS];
   logic [DW-1:0] dma_d [SLOTS];
   logic [BW-1:0] be_q [SLOTS];
   logic [BW-1:0] be_d [SLOTS];
   logic [SW-1:0] cnt_q [LINES];
   logic [SW-1:0] cnt_d [LINES];
   logic [DW-1:0] mem_out_q, mem_out_d, io_out_q, io_out_d;
   logic mem_oe_n_q, mem_oe_n_d, io_oe_n_q, io_oe_n_d;

   assign sc = dbc_sys_cmd_t'(system_buffer_command);
   assign tgt = LW'(buffer_command_qualifier);
   assign slot = cnt_q[tgt];
   assign idx = {tgt, slot};
   assign wr_idx = {mif.wr_line, mif.wr_qw};

   // next state of buffers, counters and pins
   always_comb
   begin
      wbuf_d = wbuf_q;
      rbuf_d = rbuf_q;
      dma_d = dma_q;
      be_d = be_q;
      cnt_d = cnt_q;
      mem_out_d = mem_out_q;
      io_out_d = io_out_q;
      unique case (sc)
         // reset form clears the slot counters; the hold form does nothing here
         SYS_RESET_NOP:
         begin
            if ((buffer_command_qualifier & DBC_QUAL_HOLD_BIT) == 2'h0)
            begin
               for (int l = 0; l < LINES; l++)
                  cnt_d[l] = '0;
            end
         end
         // pad and DMA-read paths belong to other parts of the slice
         SYS_LOAD_PAD, SYS_DMA_READ_SYS, SYS_DMA_READ_MEM, SYS_MERGE_READ: ;
         // plain store into the selected line
         SYS_STORE_LINE:
         begin
            wbuf_d[idx] = system_data_bus;
         end
         // pad data merged with DMA data
         SYS_MERGE_SYS_LINE:
         begin
            wbuf_d[idx] = merge_bytes(system_data_bus, dma_q[slot], be_q[slot]);
         end
         // read buffer merged with DMA data
         SYS_MERGE_MEM_LINE:
         begin
            wbuf_d[idx] = merge_bytes(rbuf_q[slot], dma_q[slot], be_q[slot]);
         end
      endcase
      if (sc == SYS_STORE_LINE || sc == SYS_MERGE_SYS_LINE || sc == SYS_MERGE_MEM_LINE)
      begin
         cnt_d[tgt] = (slot == LAST_SLOT) ? '0 : slot + 1'b1;
      end
      // capture read data on the scheduled edge
      if (mif.rd_we)
         rbuf_d[mif.rd_slot] = memory_data_bus_in;
      // drive write slot on the scheduled edge
      if (mif.wr_drive)
         mem_out_d = wbuf_q[wr_idx];
      mem_oe_n_d = mif.wr_drive ? DBC_OE_ON : DBC_OE_OFF;
      // bridge link loads the DMA buffer byte by byte
      if (io_bridge_load)
      begin
         dma_d[io_bridge_slot] = merge_bytes(dma_q[io_bridge_slot], io_bridge_data_bus_in, io_bridge_byte_en);
         be_d[io_bridge_slot] = be_q[io_bridge_slot] | io_bridge_byte_en;
      end
      // bridge link drives read buffer data; load wins if both are asked
      if (io_bridge_drive && !io_bridge_load)
         io_out_d = rbuf_q[io_bridge_slot];
      io_oe_n_d = (io_bridge_drive && !io_bridge_load) ? DBC_OE_ON : DBC_OE_OFF;
   end

   // every register back to its initial value on reset
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < NW; i++)
            wbuf_q[i] <= '0;
         for (int s = 0; s < SLOTS; s++)
         begin
            rbuf_q[s] <= '0;
            dma_q[s] <= '0;
            be_q[s] <= '0;
         end
         for (int l = 0; l < LINES; l++)
            cnt_q[l] <= '0;
         mem_out_q <= '0;
         io_out_q <= '0;
         mem_oe_n_q <= DBC_OE_OFF;
         io_oe_n_q <= DBC_OE_OFF;
      end
      else
      begin
         wbuf_q <= wbuf_d;
         rbuf_q <= rbuf_d;
         dma_q <= dma_d;
         be_q <= be_d;
         cnt_q <= cnt_d;
         mem_out_q <= mem_out_d;
         io_out_q <= io_out_d;
         mem_oe_n_q <= mem_oe_n_d;
         io_oe_n_q <= io_oe_n_d;
      end
   end

   // pins come straight from flops
   assign memory_data_bus_out = mem_out_q;
   assign memory_data_bus_oe_n = mem_oe_n_q;
   assign io_bridge_data_bus_out = io_out_q;
   assign io_bridge_data_bus_oe_n = io_oe_n_q;

   property p_store_line;
      @(posedge clock) disable iff (!reset_n)
      (sc == SYS_STORE_LINE) |=> (wbuf_q[$past(idx)] == $past(system_data_bus));
   endproperty
   a_store_line: assert property (p_store_line) else $error("store did not land in selected line");

   property p_merge_sys;
      @(posedge clock) disable iff (!reset_n)
      (sc == SYS_MERGE_SYS_LINE && be_q[slot] == '0) |=> (wbuf_q[$past(idx)] == $past(system_data_bus));
   endproperty
   a_merge_sys: assert property (p_merge_sys) else $error("merge with no DMA bytes changed pad data");

   property p_count_advance;
      @(posedge clock) disable iff (!reset_n)
      (sc == SYS_MERGE_MEM_LINE && slot != LAST_SLOT) |=> (cnt_q[$past(tgt)] == $past(slot) + 1'b1);
   endproperty
   a_count_advance: assert property (p_count_advance) else $error("line counter did not advance");

   property p_count_wrap;
      @(posedge clock) disable iff (!reset_n)
      ((sc == SYS_STORE_LINE || sc == SYS_MERGE_SYS_LINE) && slot == LAST_SLOT) |=> (cnt_q[$past(tgt)] == '0);
   endproperty
   a_count_wrap: assert property (p_count_wrap) else $error("line counter did not wrap");

   property p_write_pin;
      @(posedge clock) disable iff (!reset_n)
      mif.wr_drive |=> (memory_data_bus_oe_n == DBC_OE_ON && memory_data_bus_out == $past(wbuf_q[wr_idx]));
   endproperty
   a_write_pin: assert property (p_write_pin) else $error("write slot not driven on memory pins");

   property p_read_capture;
      @(posedge clock) disable iff (!reset_n)
      mif.rd_we |=> (rbuf_q[$past(mif.rd_slot)] == $past(memory_data_bus_in));
   endproperty
   a_read_capture: assert property (p_read_capture) else $error("read data not captured");

   property p_io_drive;
      @(posedge clock) disable iff (!reset_n)
      (io_bridge_drive && !io_bridge_load) |=> (io_bridge_data_bus_oe_n == DBC_OE_ON) ##1
         (io_bridge_data_bus_oe_n == ($past(io_bridge_drive && !io_bridge_load) ? DBC_OE_ON : DBC_OE_OFF));
   endproperty
   a_io_drive: assert property (p_io_drive) else $error("bridge link enable wrong");
endmodule : dbc_top

// File: dv/dbc_mem_model.sv
// Purpose: memory side of the data-path slice, resolving the shared memory data wire
// Assumes: memory answers reads with fresh data every cycle
// Notes: the pattern also fills idle cycles, so stale read data can never match by luck
`timescale 1ns/1ps
module dbc_mem_model
   import dbc_pkg::*;
#(
   parameter int DW = DBC_DW
)
(
   // clock
   input wire logic clock,
   // device side of the pin
   input wire logic [DW-1:0] dev_data,
   input wire logic dev_oe_n,
   // resolved wire level
   output logic [DW-1:0] bus_level
);
   logic [DW-1:0] pattern_q = DW'(32'h1234abcd);

   // new memory word each cycle, changed off the sampling edge
   always @(negedge clock)
      pattern_q <= DW'(pattern_q * 32'h0019660d + 32'h3c6ef35f);

   // the device wins the wire while it drives, memory otherwise
   assign bus_level = (dev_oe_n == DBC_OE_ON) ? dev_data : pattern_q;
endmodule : dbc_mem_model

// File: dv/dbc_top_tb_top.sv
// Purpose: self-checking bench of the buffer command decoder
// Assumes: default geometry of four lines of four slots, 32-bit words
// Notes: write data and bridge reads are compared by a monitor against queued notes
`timescale 1ns/1ps
module dbc_top_tb_top
   import dbc_pkg::*;
;
   logic clock, reset_n, memory_data_bus_oe_n, io_bridge_data_bus_oe_n, io_bridge_load, io_bridge_drive;
   logic [2:0] system_buffer_command, memory_bus_command;
   logic [1:0] buffer_command_qualifier, io_bridge_slot;
   logic [3:0] io_bridge_byte_en;
   logic [31:0] system_data_bus, io_drv, io_level, mem_level, memory_data_bus_out, io_bridge_data_bus_out;
   logic [31:0] wbuf [4][4];
   logic [31:0] rbuf [4];
   logic [31:0] dma [4];
   logic [3:0] dmabe [4];
   logic [31:0] exp_mem [$];
   logic [31:0] exp_io [$];
   int wcnt [4];
   int rcnt, wline, wqw, error_cnt, compares;

   dbc_top u_dbc_top (.clock(clock), .reset_n(reset_n), .system_buffer_command(system_buffer_command),
      .buffer_command_qualifier(buffer_command_qualifier), .system_data_bus(system_data_bus),
      .memory_bus_command(memory_bus_command), .memory_data_bus_in(mem_level),
      .memory_data_bus_out(memory_data_bus_out), .memory_data_bus_oe_n(memory_data_bus_oe_n),
      .io_bridge_data_bus_in(io_level), .io_bridge_data_bus_out(io_bridge_data_bus_out),
      .io_bridge_data_bus_oe_n(io_bridge_data_bus_oe_n), .io_bridge_load(io_bridge_load),
      .io_bridge_drive(io_bridge_drive), .io_bridge_byte_en(io_bridge_byte_en), .io_bridge_slot(io_bridge_slot));

   dbc_mem_model u_dbc_mem_model (.clock(clock), .dev_data(memory_data_bus_out),
      .dev_oe_n(memory_data_bus_oe_n), .bus_level(mem_level));

   // bridge wire: the slice wins while it drives
   assign io_level = (io_bridge_data_bus_oe_n === DBC_OE_ON) ? io_bridge_data_bus_out : io_drv;

   // 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   // reference state returns to its reset picture
   task automatic clear_model();
      foreach (wbuf[l, s]) wbuf[l][s] = 32'h0;
      foreach (rbuf[s])
      begin
         rbuf[s] = 32'h0;
         dma[s] = 32'h0;
         dmabe[s] = 4'h0;
         wcnt[s] = 0;
      end
      rcnt = 0;
      wline = 0;
      wqw = 0;
      exp_mem.delete();
      exp_io.delete();
   endtask : clear_model

   // system command and its buffer effect
   task automatic sys(input logic [2:0] c, input logic [1:0] q, input logic [31:0] d);
      int s;
      logic [31:0] src;
      @(negedge clock);
      system_buffer_command = c;
      buffer_command_qualifier = q;
      system_data_bus = d;
      s = wcnt[q];
      src = (c == 3'h7) ? rbuf[s] : d;
      if (c == 3'h0 && !q[1]) foreach (wcnt[i]) wcnt[i] = 0;
      if (c >= 3'h5)
      begin
         for (int b = 0; b < 4; b++)
            if (c != 3'h5 && dmabe[s][b]) src[8*b +: 8] = dma[s][8*b +: 8];
         wbuf[q][s] = src;
         wcnt[q] = (s + 1) % 4;
      end
   endtask : sys

   // memory command; a delayed form is followed by a no-op
   task automatic mem(input logic [2:0] c);
      int s;
      @(negedge clock);
      memory_bus_command = c;
      s = rcnt;
      case (c)
         3'h0, 3'h1:
         begin
            rcnt = (rcnt + 1) % 4;
            fork
               begin
                  // look 1 ns before the capture edge, clear of any pin change that edge launches
                  repeat (c[0] ? 2 : 1) @(posedge clock);
                  #9 rbuf[s] = mem_level;
               end
            join_none
         end
         3'h3:
         begin
            rcnt = 0;
            wqw = 0;
            wline = 0;
         end
         3'h4, 3'h5, 3'h6, 3'h7:
         begin
            exp_mem.push_back(wbuf[wline][wqw]);
            wqw = c[1] ? 0 : (wqw + 1) % 4;
            if (c[1]) wline = (wline + 1) % 4;
         end
         default: ;
      endcase
      if (c[0] && c != 3'h3) mem(3'h2);
   endtask : mem

   // bridge link load or drive; a drive beside a load is ignored
   task automatic bridge(input logic ld, input logic dr, input logic [1:0] sl, input logic [31:0] d,
                         input logic [3:0] be);
      @(negedge clock);
      io_bridge_load = ld;
      io_bridge_drive = dr;
      io_bridge_slot = sl;
      io_drv = d;
      io_bridge_byte_en = be;
      if (ld)
      begin
         for (int b = 0; b < 4; b++)
            if (be[b]) dma[sl][8*b +: 8] = d[8*b +: 8];
         dmabe[sl] |= be;
      end
      else if (dr)
         exp_io.push_back(rbuf[sl]);
   endtask : bridge

   // reset pointers, then write every slot of every line using all four write forms
   task automatic flush();
      mem(3'h3);
      for (int i = 0; i < 16; i++)
         mem(i % 4 == 3 ? {2'b11, i[2]} : {2'b10, i[0]});
      mem(3'h2);
   endtask : flush

   // monitor: every driven word takes the oldest note
   always @(negedge clock)
      if (reset_n === 1'b1)
      begin
         if (memory_data_bus_oe_n === DBC_OE_ON)
            check("memory write", memory_data_bus_out, exp_mem.size() ? exp_mem.pop_front() : 'x);
         if (io_bridge_data_bus_oe_n === DBC_OE_ON)
            check("bridge read", io_bridge_data_bus_out, exp_io.size() ? exp_io.pop_front() : 'x);
      end

   // watchdog well beyond the expected run
   initial
   begin
      repeat (5000) @(posedge clock);
      error_cnt++;
      conclude();
   end

   initial
   begin
      void'($urandom(32'h930d));
      {reset_n, io_bridge_load, io_bridge_drive, io_bridge_slot, io_bridge_byte_en} = '0;
      {system_buffer_command, buffer_command_qualifier, system_data_bus} = {3'h0, 2'h2, 32'h0};
      memory_bus_command = 3'h2;
      io_drv = 32'h0;
      clear_model();
      repeat (5) @(negedge clock);
      reset_n = 1'b1;
      check("memory enable at reset", memory_data_bus_oe_n, DBC_OE_OFF);
      check("bridge enable at reset", io_bridge_data_bus_oe_n, DBC_OE_OFF);
      $display("test reset values done");
      // five stores per line make every slot counter wrap
      for (int i = 0; i < 20; i++)
         sys(3'h5, i[1:0], $urandom);
      sys(3'h0, 2'h2, 32'h0);
      flush();
      $display("test store and write done");
      // alternating capture forms, five reads wrap the read counter
      for (int i = 0; i < 5; i++)
         mem(i[0] ? 3'h1 : 3'h0);
      // a cleared read counter sends the next capture to slot zero, not slot one
      mem(3'h3);
      mem(3'h0);
      repeat (3) mem(3'h2);
      for (int i = 0; i < 4; i++)
         bridge(1'b0, 1'b1, 2'(i), 32'h0, 4'h0);
      bridge(1'b1, 1'b1, 2'h0, $urandom, 4'h0);
      bridge(1'b0, 1'b0, 2'h0, 32'h0, 4'h0);
      $display("test read capture done");
      // accumulate byte enables, clear line counters, then both merge forms on every line
      for (int i = 0; i < 8; i++)
         bridge(1'b1, 1'b0, 2'(i), $urandom, 4'($urandom));
      bridge(1'b0, 1'b0, 2'h0, 32'h0, 4'h0);
      sys(3'h0, 2'h0, 32'h0);
      for (int i = 0; i < 16; i++)
         sys(i[3] ? 3'h7 : 3'h6, i[1:0], $urandom);
      sys(3'h0, 2'h2, 32'h0);
      // one write leaves the quadword pointer off zero, so the flush relies on the clear
      mem(3'h4);
      flush();
      $display("test merge done");
      // reset arrives while a write is still in the pipe
      mem(3'h4);
      @(negedge clock);
      reset_n = 1'b0;
      #1 check("memory enable in reset", memory_data_bus_oe_n, DBC_OE_OFF);
      check("memory data in reset", memory_data_bus_out, 32'h0);
      memory_bus_command = 3'h2;
      repeat (5) @(negedge clock);
      clear_model();
      reset_n = 1'b1;
      flush();
      repeat (4) @(negedge clock);
      $display("test mid-run reset done");
      check("pending memory writes", exp_mem.size(), 32'h0);
      check("pending bridge reads", exp_io.size(), 32'h0);
      conclude();
   end
endmodule : dbc_top_tb_top
